/* File: design/prot_elem.sv */
// protection element: pickup compare, phase voting, direction, delay, function outputs
//
// How it works
// - disabled function gives no output at all; enabled runs pickup and timer but drives no relay, trip, alarm or event output
// - trip mode raises trip, drives main trip relay, selected aux relays, trip message
// - trip-with-reclose also asserts initiate toward the autoreclose logic
// - alarm modes raise alarm, drive selected aux relays and alarm message, no trip relay
// - control mode drives selected aux relays only, no trip or alarm
// - trip, reclose, alarm and control outputs are logged as events; others not
// - any subset of aux relays three to seven is selectable
// - over elements pick up above threshold, under elements below it
// - output is held off by the programmed delay after pickup appears
// - contact-driven path adds about two power periods before trip relay
// - instantaneous AC path adds about two and a half power periods
// - aux relays close about five milliseconds after the main trip relay
// - direction disabled ignores the directional element
// - direction forward operates only while flow is forward
// - direction reverse operates only while flow is reverse
// - any-one voting needs at least one phase beyond pickup
// - any-two voting needs two or more phases beyond pickup
// - all-three voting needs every phase beyond pickup
// - comparison only runs while the run permission is one
//
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/100ps
`include "prot_elem_regs.svh"

module prot_elem
  import prot_elem_pkg::*;
#(
  parameter int unsigned MS_CYCLES   = `PE_MS_CYCLES,
  parameter int unsigned CONTACT_CYC = `PE_CONTACT_CYC,
  parameter int unsigned AC_CYC      = `PE_AC_CYC,
  parameter int unsigned AUX_CYC     = `PE_AUX_CYC
) (
  input  wire logic        clk,
  input  wire logic        reset,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // measurement and directional units, same clock
  input  wire logic [15:0] phaseA,
  input  wire logic [15:0] phaseB,
  input  wire logic [15:0] phaseC,
  input  wire logic        runEnable,
  input  wire logic        dirIsForward,
  input  wire logic        dirIsReverse,
  // contact input pin, asynchronous
  input  wire logic        contactIn,
  // outputs toward relays, autoreclose and event recorder
  output logic             tripRelay,
  output logic [4:0]       auxRelays,
  output logic             tripCondition,
  output logic             alarmCondition,
  output logic             recloseInitiate,
  output logic             tripMessage,
  output logic             alarmMessage,
  output logic             eventStrobe,
  output logic [2:0]       eventFunc
);

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  logic [`PE_CTRL_WIDTH-1:0] ctrlR;
  logic [15:0]               pickupR;
  logic [15:0]               delayR;
  logic                      latchClrPulse;

  logic [7:0]  awAddrR;
  logic        awHeldR;
  logic [31:0] wDataR;
  logic [3:0]  wStrbR;
  logic        wHeldR;
  logic        bValidR;
  logic [1:0]  bRespR;
  logic        rValidR;
  logic [31:0] rDataR;
  logic [1:0]  rRespR;

  wire awTake  = s_axi_awvalid && s_axi_awready;
  wire wTake   = s_axi_wvalid && s_axi_wready;
  wire doWrite = awHeldR && wHeldR && !bValidR;
  wire arTake  = s_axi_arvalid && s_axi_arready;

  assign s_axi_awready = !awHeldR && !bValidR;
  assign s_axi_wready  = !wHeldR && !bValidR;
  assign s_axi_bvalid  = bValidR;
  assign s_axi_bresp   = bRespR;
  assign s_axi_arready = !rValidR;
  assign s_axi_rvalid  = rValidR;
  assign s_axi_rdata   = rDataR;
  assign s_axi_rresp   = rRespR;

  wire wrCtrl   = doWrite && (awAddrR == `PE_CTRL_ADDR);
  wire wrPickup = doWrite && (awAddrR == `PE_PICKUP_ADDR);
  wire wrDelay  = doWrite && (awAddrR == `PE_DELAY_ADDR);
  wire wrCmd    = doWrite && (awAddrR == `PE_CMD_ADDR);
  wire wrStatus = doWrite && (awAddrR == `PE_STATUS_ADDR);
  wire wrHit    = wrCtrl || wrPickup || wrDelay || wrCmd || wrStatus;

  // byte-lane merge of the held write data into the control, pickup and delay registers
  logic [31:0] strbMask;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      strbMask[i*8 +: 8] = {8{wStrbR[i]}};
    end
  end

  wire [31:0] ctrlMerged   = ({{(32-`PE_CTRL_WIDTH){1'b0}}, ctrlR} & ~strbMask)
                             | (wDataR & strbMask);
  wire [31:0] pickupMerged = ({16'h0000, pickupR} & ~strbMask) | (wDataR & strbMask);
  wire [31:0] delayMerged  = ({16'h0000, delayR} & ~strbMask) | (wDataR & strbMask);

  assign latchClrPulse = wrCmd && wStrbR[0] && wDataR[`PE_CMD_LATCH_CLR];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      awHeldR <= 1'b0;
      awAddrR <= 8'h00;
    end else if (awTake) begin
      awHeldR <= 1'b1;
      awAddrR <= {s_axi_awaddr[7:2], 2'b00};
    end else if (doWrite) begin
      awHeldR <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wHeldR <= 1'b0;
      wDataR <= 32'h00000000;
      wStrbR <= 4'h0;
    end else if (wTake) begin
      wHeldR <= 1'b1;
      wDataR <= s_axi_wdata;
      wStrbR <= s_axi_wstrb;
    end else if (doWrite) begin
      wHeldR <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bValidR <= 1'b0;
      bRespR  <= 2'b00;
    end else if (doWrite) begin
      bValidR <= 1'b1;
      bRespR  <= wrHit ? 2'b00 : 2'b11;
    end else if (s_axi_bready) begin
      bValidR <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrlR   <= `PE_CTRL_RST;
      pickupR <= `PE_PICKUP_RST;
      delayR  <= `PE_DELAY_RST;
    end else begin
      if (wrCtrl)
        ctrlR <= ctrlMerged[`PE_CTRL_WIDTH-1:0];
      if (wrPickup)
        pickupR <= pickupMerged[15:0];
      if (wrDelay)
        delayR <= delayMerged[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // settings decode

  wire [2:0] funcBits = ctrlR[`PE_CTRL_FUNC_MSB:`PE_CTRL_FUNC_LSB];
  func_t      funcSel;
  dir_t       dirSel;
  phase_req_t phSel;
  assign funcSel = (funcBits <= 3'h6) ? func_t'(funcBits) : FN_DISABLED;
  assign dirSel  = dir_t'(ctrlR[`PE_CTRL_DIR_MSB:`PE_CTRL_DIR_LSB]);
  assign phSel   = phase_req_t'(ctrlR[`PE_CTRL_PH_MSB:`PE_CTRL_PH_LSB]);
  wire        underType  = ctrlR[`PE_CTRL_UNDER];
  wire        contactSrc = ctrlR[`PE_CTRL_CONTACT];
  wire [4:0]  relaySel   = ctrlR[`PE_CTRL_RLY_MSB:`PE_CTRL_RLY_LSB];

  ////////////////////////////////////////////////////////////////////////////////
  // measuring element

  logic contactMeta;
  logic contactSync;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      contactMeta <= 1'b0;
      contactSync <= 1'b0;
    end else begin
      contactMeta <= contactIn;
      contactSync <= contactMeta;
    end
  end

  wire [15:0] phaseVal [3];
  assign phaseVal[0] = phaseA;
  assign phaseVal[1] = phaseB;
  assign phaseVal[2] = phaseC;

  logic [2:0] beyond;
  for (genvar p = 0; p < 3; p++) begin : g_phase
    assign beyond[p] = runEnable && (underType ? (phaseVal[p] < pickupR)
                                               : (phaseVal[p] > pickupR));
  end

  wire [1:0] beyondCount = 2'(beyond[0]) + 2'(beyond[1]) + 2'(beyond[2]);

  logic voteOk;
  always_comb begin
    case (phSel)
      PH_ANY_ONE:   voteOk = beyondCount >= 2'd1;
      PH_ANY_TWO:   voteOk = beyondCount >= 2'd2;
      PH_ALL_THREE: voteOk = beyondCount == 2'd3;
      default:      voteOk = 1'b0;
    endcase
  end

  logic dirOk;
  always_comb begin
    case (dirSel)
      DIR_DISABLED: dirOk = 1'b1;
      DIR_FORWARD:  dirOk = dirIsForward;
      DIR_REVERSE:  dirOk = dirIsReverse;
      default:      dirOk = 1'b0;
    endcase
  end

  // contact source still needs run permission but skips compare and direction
  wire srcActive = contactSrc ? (contactSync && runEnable) : (voteOk && dirOk);
  wire pickupNow = srcActive && (funcSel != FN_DISABLED);

  ////////////////////////////////////////////////////////////////////////////////
  // delay timer: programmed ms delay, then path latency

  timer_state_t stateR;
  timer_state_t stateNxt;
  logic [31:0]  cycR;
  logic [31:0]  cycNxt;
  logic [15:0]  msR;
  logic [15:0]  msNxt;

  wire [31:0] latencyCyc = contactSrc ? CONTACT_CYC : AC_CYC;
  wire        msTick     = (cycR == MS_CYCLES - 1);

  always_comb begin
    stateNxt = stateR;
    cycNxt   = cycR;
    msNxt    = msR;
    if (!pickupNow) begin
      stateNxt = ST_IDLE;
      cycNxt   = 32'h00000000;
      msNxt    = 16'h0000;
    end else begin
      case (stateR)
        ST_IDLE: begin
          stateNxt = (delayR == 16'h0000) ? ST_LATENCY : ST_DELAY;
          cycNxt   = 32'h00000000;
          msNxt    = 16'h0000;
        end
        ST_DELAY: begin
          cycNxt = msTick ? 32'h00000000 : cycR + 32'h00000001;
          if (msTick) begin
            msNxt = msR + 16'h0001;
            if (msR + 16'h0001 == delayR)
              stateNxt = ST_LATENCY;
          end
        end
        ST_LATENCY: begin
          cycNxt = cycR + 32'h00000001;
          if (cycR + 32'h00000001 >= latencyCyc) begin
            stateNxt = ST_OPERATED;
            cycNxt   = 32'h00000000;
          end
        end
        ST_OPERATED: begin
          if (cycR < AUX_CYC)
            cycNxt = cycR + 32'h00000001;
        end
        default: stateNxt = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stateR <= ST_IDLE;
      cycR   <= 32'h00000000;
      msR    <= 16'h0000;
    end else begin
      stateR <= stateNxt;
      cycR   <= cycNxt;
      msR    <= msNxt;
    end
  end

  wire operated = (stateR == ST_OPERATED);
  wire auxReady = operated && (cycR >= AUX_CYC);

  ////////////////////////////////////////////////////////////////////////////////
  // function outputs

  wire isTrip    = (funcSel == FN_TRIP) || (funcSel == FN_TRIP_WITH_RECLOSE);
  wire isAlarm   = (funcSel == FN_ALARM) || (funcSel == FN_LATCHED_ALARM);
  wire isControl = (funcSel == FN_CONTROL);
  wire isLogged  = isTrip || isAlarm || isControl;

  // latch survives pickup loss; a new alarm in the clear cycle keeps it set
  logic latchR;
  wire  latchSet = operated && (funcSel == FN_LATCHED_ALARM);
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      latchR <= 1'b0;
    else if (latchSet)
      latchR <= 1'b1;
    else if (latchClrPulse || funcSel != FN_LATCHED_ALARM)
      latchR <= 1'b0;
  end

  wire alarmHold = latchR && (funcSel == FN_LATCHED_ALARM);
  wire tripNxt   = operated && isTrip;
  wire alarmNxt  = (operated && isAlarm) || alarmHold;
  wire drvAux    = (auxReady && (isTrip || isControl || isAlarm))
                   || (alarmHold && !operated);
  logic operatedD;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tripRelay       <= 1'b0;
      auxRelays       <= 5'h00;
      tripCondition   <= 1'b0;
      alarmCondition  <= 1'b0;
      recloseInitiate <= 1'b0;
      tripMessage     <= 1'b0;
      alarmMessage    <= 1'b0;
      eventStrobe     <= 1'b0;
      eventFunc       <= 3'h0;
      operatedD       <= 1'b0;
    end else begin
      tripRelay       <= tripNxt;
      auxRelays       <= drvAux ? relaySel : 5'h00;
      tripCondition   <= tripNxt;
      alarmCondition  <= alarmNxt;
      recloseInitiate <= tripNxt && (funcSel == FN_TRIP_WITH_RECLOSE);
      tripMessage     <= tripNxt;
      alarmMessage    <= alarmNxt;
      operatedD       <= operated;
      eventStrobe     <= operated && !operatedD && isLogged;
      eventFunc       <= funcBits;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register read

  wire [31:0] statusWord = {16'h0000, 3'b000, auxRelays, stateR, recloseInitiate,
                            alarmCondition, tripCondition, tripRelay, operated, pickupNow};

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rValidR <= 1'b0;
      rDataR  <= 32'h00000000;
      rRespR  <= 2'b00;
    end else if (arTake) begin
      rValidR <= 1'b1;
      rRespR  <= 2'b00;
      case ({s_axi_araddr[7:2], 2'b00})
        `PE_CTRL_ADDR:   rDataR <= {{(32-`PE_CTRL_WIDTH){1'b0}}, ctrlR};
        `PE_PICKUP_ADDR: rDataR <= {16'h0000, pickupR};
        `PE_DELAY_ADDR:  rDataR <= {16'h0000, delayR};
        `PE_STATUS_ADDR: rDataR <= statusWord;
        `PE_CMD_ADDR:    rDataR <= 32'h00000000;
        default: begin
          rDataR <= 32'h00000000;
          rRespR <= 2'b11;
        end
      endcase
    end else if (s_axi_rready) begin
      rValidR <= 1'b0;
    end
  end

endmodule : prot_elem

/* File: dv/feeder_model.sv */
// feeder side: phase levels, direction report, contact pin
`timescale 1ns/100ps
module feeder_model (
  input  wire logic       clk,
  input  wire logic [2:0] faultMask,
  input  wire logic [1:0] flowDir,
  input  wire logic       runCmd,
  input  wire logic       contactCmd,
  output logic [15:0]     phaseA,
  output logic [15:0]     phaseB,
  output logic [15:0]     phaseC,
  output logic            runEnable,
  output logic            dirIsForward,
  output logic            dirIsReverse,
  output logic            contactIn
);
  localparam logic [15:0] FaultLvl = 16'h2000;
  localparam logic [15:0] LoadLvl = 16'h0800;
  initial {phaseA, phaseB, phaseC, runEnable, dirIsForward, dirIsReverse, contactIn} = '0;
  always @(posedge clk) begin
    phaseA <= faultMask[0] ? FaultLvl : LoadLvl;
    phaseB <= faultMask[1] ? FaultLvl : LoadLvl;
    phaseC <= faultMask[2] ? FaultLvl : LoadLvl;
    runEnable <= runCmd;
    // forward and reverse are never reported together
    dirIsForward <= flowDir == 2'd1;
    dirIsReverse <= flowDir == 2'd2;
  end
  // contact pin has no phase relation to clk
  always @(contactCmd) contactIn <= #7 contactCmd;
endmodule : feeder_model

/* File: dv/prot_elem_properties.sv */
// port assertions for the protection element
`timescale 1ns/100ps
module prot_elem_chk #(
  parameter int unsigned AUX_CYC = 5
) (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        tripRelay,
  input wire logic [4:0]  auxRelays,
  input wire logic        tripCondition,
  input wire logic        alarmCondition,
  input wire logic        recloseInitiate,
  input wire logic        tripMessage,
  input wire logic        alarmMessage,
  input wire logic        eventStrobe,
  input wire logic [2:0]  eventFunc
);
  localparam int LagLo = AUX_CYC - 2;
  localparam int LagHi = AUX_CYC + 1;
  logic [7:0] lagCnt_r;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  //////////////////////////////////////////
  // saturates so a long trip never wraps back into the window
  always_ff @(posedge clk or posedge reset) begin
    if (reset) lagCnt_r <= 8'h00;
    else if (!tripRelay) lagCnt_r <= 8'h00;
    else if (lagCnt_r != 8'hff) lagCnt_r <= lagCnt_r + 8'h01;
  end
  chk_trip_cond: assert property (tripRelay |-> tripCondition && tripMessage)
    else $error("trip relay without trip condition");
  chk_alarm_notrip: assert property (alarmCondition |-> alarmMessage && !tripRelay)
    else $error("alarm with trip relay or no message");
  chk_reclose_trip: assert property (recloseInitiate |-> tripCondition)
    else $error("reclose initiate without trip");
  chk_evt_func: assert property (eventStrobe |-> eventFunc inside {[3'h2:3'h6]})
    else $error("event logged for unlogged function");
  chk_evt_pulse: assert property (eventStrobe |=> !eventStrobe)
    else $error("event strobe longer than one cycle");
  chk_aux_lag: assert property ($rose(auxRelays != 5'h00) && tripRelay |->
    lagCnt_r >= LagLo && lagCnt_r <= LagHi) else $error("aux relays not lagging trip");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
endmodule : prot_elem_chk

bind prot_elem prot_elem_chk #(.AUX_CYC(AUX_CYC)) u_chk (
  .clk(clk), .reset(reset), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .tripRelay(tripRelay), .auxRelays(auxRelays),
  .tripCondition(tripCondition), .alarmCondition(alarmCondition),
  .recloseInitiate(recloseInitiate), .tripMessage(tripMessage),
  .alarmMessage(alarmMessage), .eventStrobe(eventStrobe), .eventFunc(eventFunc)
);

/* File: dv/tb_prot_elem.sv */
// self-checking bench for the protection element
`timescale 1ns/100ps
`include "prot_elem_regs.svh"
module tb_prot_elem import prot_elem_pkg::*; ;
  localparam int M = 4;
  localparam int C = 6;
  localparam int L = 8;
  localparam int A = 5;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] awAddr = 8'h00, arAddr = 8'h00;
  logic [31:0] wData = 32'h0, rData;
  logic awValid = 1'b0, wValid = 1'b0, arValid = 1'b0, bReady = 1'b0, rReady = 1'b0;
  logic awReady, wReady, bValid, arReady, rValid;
  logic [1:0] bResp, rResp, flowDir = 2'h0;
  logic [2:0] faultMask = 3'h0, evtFunc, evtLast;
  logic runCmd = 1'b1, contactCmd = 1'b0;
  logic [15:0] phA, phB, phC;
  logic runEn, dirFwd, dirRev, contactIn, tripRelay, tripCond, alarmCond;
  logic reclose, tripMsg, alarmMsg, evtStb;
  logic [4:0] auxRelays;
  int failCount = 0, cmpCount = 0, evtCnt = 0;

  prot_elem #(.MS_CYCLES(M), .CONTACT_CYC(C), .AC_CYC(L), .AUX_CYC(A)) u_dut (
    .clk(clk), .reset(reset), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .phaseA(phA), .phaseB(phB), .phaseC(phC), .runEnable(runEn),
    .dirIsForward(dirFwd), .dirIsReverse(dirRev), .contactIn(contactIn),
    .tripRelay(tripRelay), .auxRelays(auxRelays), .tripCondition(tripCond),
    .alarmCondition(alarmCond), .recloseInitiate(reclose), .tripMessage(tripMsg),
    .alarmMessage(alarmMsg), .eventStrobe(evtStb), .eventFunc(evtFunc)
  );
  feeder_model u_feed (
    .clk(clk), .faultMask(faultMask), .flowDir(flowDir), .runCmd(runCmd),
    .contactCmd(contactCmd), .phaseA(phA), .phaseB(phB), .phaseC(phC),
    .runEnable(runEn), .dirIsForward(dirFwd), .dirIsReverse(dirRev), .contactIn(contactIn)
  );
  initial begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    if (evtStb === 1'b1) begin
      evtCnt++;
      evtLast = evtFunc;
    end
  end
  //////////////////////////////////////////
  task automatic end_sim;
    if (failCount == 0 && cmpCount > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim
  task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] got);
    cmpCount++;
    if (got !== ex) begin
      failCount++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask : cmp
  task automatic stall;
    cmp("handshake", 1, 0);
    end_sim();
  endtask : stall
  // ready rises only once valid is seen, so the response hold checks get exercised
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (awReady === 1'b1) awValid <= 1'b0;
      if (wReady === 1'b1) wValid <= 1'b0;
      if (bValid === 1'b1 && bReady === 1'b1) break;
      if (bValid === 1'b1) bReady <= 1'b1;
    end
    bReady <= 1'b0;
    if (i == 40) stall();
    cmp("bresp", er, bResp);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
    int i;
    arAddr <= a;
    arValid <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (arReady === 1'b1) arValid <= 1'b0;
      if (rValid === 1'b1 && rReady === 1'b1) break;
      if (rValid === 1'b1) rReady <= 1'b1;
    end
    rReady <= 1'b0;
    if (i == 40) stall();
    cmp("rdata", ex, rData);
    cmp("rresp", er, rResp);
  endtask : rdc
  function automatic logic [31:0] cw(func_t f, logic [1:0] d, logic [1:0] p,
                                     logic u, logic c, logic [4:0] r);
    return {18'h0, r, c, u, p, d, f};
  endfunction : cw
  task automatic setup(input logic [31:0] c, input logic [15:0] dly);
    wr(`PE_CTRL_ADDR, c, 2'b00);
    wr(`PE_DELAY_ADDR, {16'h0, dly}, 2'b00);
  endtask : setup
  task automatic feed(input logic [2:0] m, input logic [1:0] fd, input logic r, input logic c);
    faultMask <= m;
    flowDir <= fd;
    runCmd <= r;
    contactCmd <= c;
  endtask : feed
  // n is 0 when nothing operated within lim cycles
  task automatic waitOp(input int lim, output int n);
    for (n = 1; n <= lim; n++) begin
      @(posedge clk);
      if ((tripRelay | tripCond | alarmCond | (|auxRelays)) === 1'b1) return;
    end
    n = 0;
  endtask : waitOp
  task automatic quiet;
    feed(3'b000, 2'd0, 1'b1, 1'b0);
    repeat (6) @(posedge clk);
  endtask : quiet
  //////////////////////////////////////////
  task automatic s_regs;
    rdc(`PE_CTRL_ADDR, 32'h0, 2'b00);
    rdc(`PE_PICKUP_ADDR, 32'hffff, 2'b00);
    rdc(`PE_DELAY_ADDR, 32'h0, 2'b00);
    rdc(8'h14, 32'h0, 2'b11);
    wr(8'h14, 32'h1, 2'b11);
    wr(`PE_PICKUP_ADDR, 32'h1000, 2'b00);
    rdc(`PE_PICKUP_ADDR, 32'h1000, 2'b00);
  endtask : s_regs
  task automatic s_modes;
    int n;
    int e;
    logic [4:0] sel;
    logic tr;
    logic al;
    for (int k = 2; k <= 6; k++) begin
      sel = k[0] ? 5'h15 : 5'h0a;
      tr = k < 4;
      al = k == 4 || k == 5;
      setup(cw(func_t'(k), 2'd0, 2'd0, 1'b0, 1'b0, sel), 16'd2);
      e = evtCnt;
      feed(3'b001, 2'd0, 1'b1, 1'b0);
      waitOp(80, n);
      if (tr) cmp("trip delay", 1, n >= 2 * M + L + 3 && n <= 2 * M + L + 5);
      cmp("trip", tr, tripRelay);
      cmp("trip msg", tr, tripMsg);
      cmp("trip cond", tr, tripCond);
      cmp("reclose", k == 3, reclose);
      cmp("alarm", al, alarmCond);
      cmp("alarm msg", al, alarmMsg);
      cmp("aux early", k == 6 ? sel : 5'h00, auxRelays);
      if (k == 2) rdc(`PE_STATUS_ADDR, 32'hcf, 2'b00);
      repeat (A + 2) @(posedge clk);
      cmp("aux", sel, auxRelays);
      cmp("events", e + 1, evtCnt);
      if (k != 5) cmp("event func", k, evtLast);
      quiet();
      cmp("alarm hold", k == 5, alarmCond);
      wr(`PE_CMD_ADDR, 32'h1, 2'b00);
      repeat (3) @(posedge clk);
      cmp("cleared", 0, tripRelay | alarmCond | (|auxRelays));
    end
  endtask : s_modes
  task automatic s_vote;
    int n;
    for (int p = 0; p < 3; p++) begin
      setup(cw(FN_TRIP, 2'd0, p[1:0], 1'b0, 1'b0, 5'h00), 16'd0);
      for (int c = 1; c <= 3; c++) begin
        feed(3'b111 << (3 - c), 2'd0, 1'b1, 1'b0);
        waitOp(30, n);
        cmp("vote", c > p, n != 0);
        quiet();
      end
    end
  endtask : s_vote
  task automatic s_dir;
    int n;
    for (int d = 0; d < 3; d++) begin
      setup(cw(FN_TRIP, d[1:0], 2'd0, 1'b0, 1'b0, 5'h00), 16'd0);
      for (int f = 0; f < 3; f++) begin
        feed(3'b111, f[1:0], 1'b1, 1'b0);
        waitOp(30, n);
        cmp("direction", d == 0 || d == f, n != 0);
        quiet();
      end
    end
  endtask : s_dir
  task automatic s_misc;
    int n;
    int e;
    // levels high first, or the under element picks up on load during setup
    feed(3'b111, 2'd0, 1'b1, 1'b0);
    setup(cw(FN_TRIP, 2'd0, 2'd0, 1'b1, 1'b0, 5'h00), 16'd0);
    waitOp(30, n);
    cmp("under high", 0, n != 0);
    feed(3'b110, 2'd0, 1'b1, 1'b0);
    waitOp(30, n);
    cmp("under low", 1, n != 0);
    setup(cw(FN_TRIP, 2'd0, 2'd0, 1'b0, 1'b0, 5'h00), 16'd2);
    quiet();
    feed(3'b111, 2'd0, 1'b0, 1'b0);
    waitOp(40, n);
    cmp("no run", 0, n != 0);
    feed(3'b111, 2'd0, 1'b1, 1'b0);
    repeat (6) @(posedge clk);
    feed(3'b111, 2'd0, 1'b0, 1'b0);
    @(posedge clk);
    feed(3'b111, 2'd0, 1'b1, 1'b0);
    waitOp(40, n);
    cmp("restart", 1, n >= 2 * M + L + 3);
    quiet();
    setup(cw(FN_TRIP, 2'd0, 2'd0, 1'b0, 1'b1, 5'h00), 16'd1);
    feed(3'b000, 2'd0, 1'b1, 1'b1);
    waitOp(40, n);
    cmp("contact delay", 1, n >= M + C + 4 && n <= M + C + 7);
    quiet();
    for (int f = 0; f < 2; f++) begin
      setup(cw(func_t'(f), 2'd0, 2'd0, 1'b0, 1'b0, 5'h1f), 16'd0);
      e = evtCnt;
      feed(3'b111, 2'd0, 1'b1, 1'b0);
      waitOp(40, n);
      cmp("silent", 0, n != 0);
      cmp("no event", e, evtCnt);
      quiet();
    end
  endtask : s_misc
  //////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    s_regs();
    s_modes();
    s_vote();
    s_dir();
    s_misc();
    end_sim();
  end
endmodule : tb_prot_elem

/* File: shared/prot_elem_pkg.sv */
// types shared by the protection element and its bench
package prot_elem_pkg;

  typedef enum logic [2:0] {
    FN_DISABLED,
    FN_ENABLED,
    FN_TRIP,
    FN_TRIP_WITH_RECLOSE,
    FN_ALARM,
    FN_LATCHED_ALARM,
    FN_CONTROL
  } func_t;

  typedef enum logic [1:0] {
    DIR_DISABLED,
    DIR_FORWARD,
    DIR_REVERSE
  } dir_t;

  typedef enum logic [1:0] {
    PH_ANY_ONE,
    PH_ANY_TWO,
    PH_ALL_THREE
  } phase_req_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DELAY,
    ST_LATENCY,
    ST_OPERATED
  } timer_state_t;

endpackage : prot_elem_pkg

/* File: shared/prot_elem_regs.svh */
// register map, field positions, reset values and timing figures of the protection element
`ifndef PROT_ELEM_REGS_SVH
`define PROT_ELEM_REGS_SVH

// byte addresses on the register bus
`define PE_CTRL_ADDR      8'h00
`define PE_PICKUP_ADDR    8'h04
`define PE_DELAY_ADDR     8'h08
`define PE_STATUS_ADDR    8'h0c
`define PE_CMD_ADDR       8'h10

// control register fields
`define PE_CTRL_FUNC_LSB  0
`define PE_CTRL_FUNC_MSB  2
`define PE_CTRL_DIR_LSB   3
`define PE_CTRL_DIR_MSB   4
`define PE_CTRL_PH_LSB    5
`define PE_CTRL_PH_MSB    6
`define PE_CTRL_UNDER     7
`define PE_CTRL_CONTACT   8
`define PE_CTRL_RLY_LSB   9
`define PE_CTRL_RLY_MSB   13
`define PE_CTRL_WIDTH     14

// command register fields
`define PE_CMD_LATCH_CLR  0

// reset values
`define PE_CTRL_RST       14'h0000
`define PE_PICKUP_RST     16'hffff
`define PE_DELAY_RST      16'h0000

// timing figures
`define PE_CLK_HZ         50000000
`define PE_POWER_HZ       60
`define PE_MS_PER_S       1000
`define PE_AUX_LAG_MS     5
`define PE_MS_CYCLES      (`PE_CLK_HZ / `PE_MS_PER_S)
`define PE_CONTACT_CYC    ((`PE_CLK_HZ * 2) / `PE_POWER_HZ)
`define PE_AC_CYC         ((`PE_CLK_HZ * 5) / (2 * `PE_POWER_HZ))
`define PE_AUX_CYC        (`PE_AUX_LAG_MS * `PE_MS_CYCLES)

`endif
